// file: logic/caif_pkg.sv
`default_nettype none
package caif_pkg;

  localparam int PC_W = 22;

  // status flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;

  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [5:0] M_ALL       = 6'h3f;
  localparam logic [5:0] M_ZCNVS     = 6'h1f;
  localparam logic [5:0] M_ZNVS      = 6'h1e;
  localparam logic [5:0] M_ZC        = 6'h03;
  localparam logic [5:0] M_NONE      = 6'h00;

  // cycles per operation
  localparam logic [1:0] CYC_ONE      = 2'h1;
  localparam logic [1:0] CYC_TWO      = 2'h2;
  localparam logic [1:0] CYC_CALL_IND = 2'h2;

  typedef enum logic [4:0] {
    OP_ADD           = 5'h00, OP_ADD_CARRY  = 5'h01, OP_ADD_IMM_WORD = 5'h02,
    OP_SUB           = 5'h03, OP_SUB_IMM    = 5'h04, OP_SUB_CARRY    = 5'h05,
    OP_SUB_IMM_BORROW = 5'h06, OP_SUB_IMM_WORD = 5'h07, OP_AND       = 5'h08,
    OP_AND_IMM       = 5'h09, OP_OR         = 5'h0a, OP_OR_IMM       = 5'h0b,
    OP_XOR           = 5'h0c, OP_ONES_COMP  = 5'h0d, OP_TWOS_COMP    = 5'h0e,
    OP_SET_BITS      = 5'h0f, OP_CLEAR_BITS = 5'h10, OP_INCR         = 5'h11,
    OP_DECR          = 5'h12, OP_TEST_ZM    = 5'h13, OP_CLEAR_REG    = 5'h14,
    OP_SET_REG       = 5'h15, OP_MUL_UU     = 5'h16, OP_MUL_SS       = 5'h17,
    OP_MUL_SU        = 5'h18, OP_FMUL_UU    = 5'h19, OP_FMUL_SS      = 5'h1a,
    OP_FMUL_SU       = 5'h1b, OP_JUMP_IND   = 5'h1c, OP_CALL_IND     = 5'h1d
  } caif_op_e;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_SECOND = 2'b10
  } caif_state_e;

  typedef struct packed {
    caif_op_e    op;
    logic [7:0]  rd;
    logic [7:0]  rdHigh;
    logic [7:0]  rr;
    logic [7:0]  imm;
    logic [15:0] zPtr;
  } caif_req_s;

  typedef struct packed {
    logic        wrEn;
    logic        wrWide;
    logic        toR1R0;
    logic [15:0] data;
  } caif_result_s;

endpackage
`default_nettype wire

// file: logic/caif_mult.sv
`timescale 1ns/1ns
`default_nettype none
module caif_mult (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        load,
  input  wire logic [7:0]  opA,
  input  wire logic [7:0]  opB,
  input  wire logic        signA,
  input  wire logic        signB,
  output var  logic [15:0] product
);
  // sign-extend signed operands and zero-extend unsigned ones to 9 bits so one signed multiplier covers all mixes
  wire logic signed [8:0]  extA = {signA & opA[7], opA};
  wire logic signed [8:0]  extB = {signB & opB[7], opB};
  wire logic signed [17:0] full = extA * extB;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      product <= 16'h0000;
    end else if (load) begin
      product <= full[15:0];
    end
  end
endmodule
`default_nettype wire

// file: logic/caif_alu.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Adding an immediate to a register pair writes the 16-bit sum, updates Z C N V S, takes two cycles.
// - Subtracting an immediate from a pair writes the difference, updates Z C N V S not H, two cycles.
// - Subtract immediate with borrow stores rd minus constant minus carry, all six flags, one cycle.
// - AND with immediate stores the conjunction, updates only Z N V S, one cycle.
// - OR with immediate stores the disjunction, updates only Z N V S, one cycle.
// - Test for zero or minus leaves the register unchanged and updates Z N V S in one cycle.
// - Set bits ORs the register with the mask, stores it, updates Z N V S, one cycle.
// - Clear bits ANDs the register with the inverted mask, stores it, updates Z N V S, one cycle.
// - Signed by unsigned multiply puts the 16-bit product in r1:r0, updates Z and C, two cycles.
// - Fractional signed by unsigned multiply stores the product shifted left once, Z and C, two cycles.
// - Indirect jump loads pc 15..0 from Z, clears pc 21..16, keeps flags, two cycles.
// - Indirect call loads low pc bits from Z, zeroes the upper bits, keeps flags, two cycles here.
module caif_alu (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic                  reqValid,
  input  wire caif_pkg::caif_req_s   req,
  output var  logic                  reqReady,
  output var  logic                  done,
  output var  caif_pkg::caif_result_s result,
  output var  logic [5:0]            flags,
  output var  logic                  pcLoad,
  output var  logic [21:0]           pcValue
);
  import caif_pkg::*;

  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic ci);
    logic [7:0] r;
    r = a + b + {7'h00, ci};
    add8 = {(a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]),
            (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]),
            (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]), r};
  endfunction

  function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                       input logic ci);
    logic [7:0] r;
    r = a - b - {7'h00, ci};
    sub8 = {(~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]),
            (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]),
            (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]), r};
  endfunction

  // h, v, c, result packed as add8/sub8 return them
  function automatic logic [5:0] arithFl(input logic [10:0] t);
    logic [5:0] f;
    f = 6'h00;
    f[FLG_H] = t[10];
    f[FLG_V] = t[9];
    f[FLG_C] = t[8];
    f[FLG_N] = t[7];
    f[FLG_Z] = (t[7:0] == 8'h00);
    f[FLG_S] = t[7] ^ t[9];
    arithFl = f;
  endfunction

  function automatic logic [1:0] opCycles(input caif_op_e op);
    unique case (op)
      OP_ADD_IMM_WORD, OP_SUB_IMM_WORD, OP_MUL_UU, OP_MUL_SS, OP_MUL_SU,
      OP_FMUL_UU, OP_FMUL_SS, OP_FMUL_SU, OP_JUMP_IND: opCycles = CYC_TWO;
      OP_CALL_IND: opCycles = CYC_CALL_IND;
      default:     opCycles = CYC_ONE;
    endcase
  endfunction

  caif_state_e  state;
  caif_state_e  next_state;
  caif_req_s    held;
  logic [15:0]  product;
  logic [5:0]   calcFl;
  logic [5:0]   affect;
  caif_result_s next_result;

  wire logic      accept   = reqValid && reqReady;
  wire logic      twoCyc   = opCycles(req.op) != CYC_ONE;
  wire logic      inSecond = (state == ST_SECOND);
  wire logic      finish   = (accept && !twoCyc) || inSecond;
  wire caif_req_s cur      = inSecond ? held : req;
  wire logic      carryIn  = flags[FLG_C];
  wire logic [15:0] pairVal = {cur.rdHigh, cur.rd};
  wire logic [15:0] pairSum = pairVal + {8'h00, cur.imm};
  wire logic [15:0] pairDif = pairVal - {8'h00, cur.imm};
  wire logic      signA = (req.op == OP_MUL_SS) || (req.op == OP_MUL_SU) ||
                          (req.op == OP_FMUL_SS) || (req.op == OP_FMUL_SU);
  wire logic      signB = (req.op == OP_MUL_SS) || (req.op == OP_FMUL_SS);
  wire logic      fracOp = (cur.op == OP_FMUL_UU) || (cur.op == OP_FMUL_SS) ||
                           (cur.op == OP_FMUL_SU);
  wire logic [15:0] mulRes = fracOp ? {product[14:0], 1'b0} : product;
  wire logic      pcOp = (cur.op == OP_JUMP_IND) || (cur.op == OP_CALL_IND);
  wire logic [5:0] next_flags = (flags & ~affect) | (calcFl & affect);

  assign reqReady   = (state == ST_IDLE);
  assign next_state = (accept && twoCyc) ? ST_SECOND : ST_IDLE;

  caif_mult u_mult (
    .core_clk (core_clk),
    .reset    (reset),
    .load     (accept),
    .opA      (req.rd),
    .opB      (req.rr),
    .signA    (signA),
    .signB    (signB),
    .product  (product)
  );

  always_comb begin
    logic [10:0] t;
    logic [15:0] w;
    t = 11'h000;
    w = 16'h0000;
    next_result = '{wrEn: 1'b1, wrWide: 1'b0, toR1R0: 1'b0, data: 16'h0000};
    affect = M_ZNVS;
    calcFl = 6'h00;
    unique case (cur.op)
      OP_ADD:            t = add8(cur.rd, cur.rr, 1'b0);
      OP_ADD_CARRY:      t = add8(cur.rd, cur.rr, carryIn);
      OP_SUB:            t = sub8(cur.rd, cur.rr, 1'b0);
      OP_SUB_IMM:        t = sub8(cur.rd, cur.imm, 1'b0);
      OP_SUB_CARRY:      t = sub8(cur.rd, cur.rr, carryIn);
      OP_SUB_IMM_BORROW: t = sub8(cur.rd, cur.imm, carryIn);
      OP_TWOS_COMP:      t = sub8(8'h00, cur.rd, 1'b0);
      OP_AND:            t = {3'h0, cur.rd & cur.rr};
      OP_AND_IMM:        t = {3'h0, cur.rd & cur.imm};
      OP_OR:             t = {3'h0, cur.rd | cur.rr};
      OP_OR_IMM:         t = {3'h0, cur.rd | cur.imm};
      OP_XOR:            t = {3'h0, cur.rd ^ cur.rr};
      OP_SET_BITS:       t = {3'h0, cur.rd | cur.imm};
      OP_CLEAR_BITS:     t = {3'h0, cur.rd & ~cur.imm};
      OP_TEST_ZM:        t = {3'h0, cur.rd & cur.rd};
      OP_ONES_COMP:      t = {3'h1, 8'hff - cur.rd};
      OP_INCR:           t = {1'b0, cur.rd == 8'h7f, 1'b0, cur.rd + 8'h01};
      OP_DECR:           t = {1'b0, cur.rd == 8'h80, 1'b0, cur.rd - 8'h01};
      OP_CLEAR_REG:      t = {3'h0, cur.rd ^ cur.rd};
      OP_SET_REG:        t = {3'h0, 8'hff};
      OP_ADD_IMM_WORD:   w = pairSum;
      OP_SUB_IMM_WORD:   w = pairDif;
      OP_MUL_UU, OP_MUL_SS, OP_MUL_SU, OP_FMUL_UU, OP_FMUL_SS, OP_FMUL_SU:
                         w = mulRes;
      OP_JUMP_IND, OP_CALL_IND: w = 16'h0000;
      // released operand lines can carry unused codes
      default:           t = 11'h000;
    endcase
    calcFl = arithFl(t);
    next_result.data = {8'h00, t[7:0]};
    unique case (cur.op)
      OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_IMM, OP_TWOS_COMP:
        affect = M_ALL;
      OP_SUB_CARRY, OP_SUB_IMM_BORROW: begin
        affect = M_ALL;
        // a borrow chain only stays zero if every byte was zero
        calcFl[FLG_Z] = (t[7:0] == 8'h00) && flags[FLG_Z];
      end
      OP_ONES_COMP:      affect = M_ZCNVS;
      OP_TEST_ZM:        next_result.wrEn = 1'b0;
      OP_SET_REG:        affect = M_NONE;
      OP_ADD_IMM_WORD, OP_SUB_IMM_WORD: begin
        affect = M_ZCNVS;
        next_result.wrWide = 1'b1;
        next_result.data = w;
        calcFl[FLG_Z] = (w == 16'h0000);
        calcFl[FLG_N] = w[15];
        if (cur.op == OP_ADD_IMM_WORD) begin
          calcFl[FLG_V] = ~pairVal[15] & w[15];
          calcFl[FLG_C] = ~w[15] & pairVal[15];
        end else begin
          calcFl[FLG_V] = pairVal[15] & ~w[15];
          calcFl[FLG_C] = w[15] & ~pairVal[15];
        end
        calcFl[FLG_S] = calcFl[FLG_N] ^ calcFl[FLG_V];
      end
      OP_MUL_UU, OP_MUL_SS, OP_MUL_SU, OP_FMUL_UU, OP_FMUL_SS, OP_FMUL_SU: begin
        affect = M_ZC;
        next_result.toR1R0 = 1'b1;
        next_result.wrWide = 1'b1;
        next_result.data = w;
        calcFl[FLG_Z] = (w == 16'h0000);
        calcFl[FLG_C] = product[15];
      end
      OP_JUMP_IND, OP_CALL_IND: begin
        affect = M_NONE;
        next_result.wrEn = 1'b0;
      end
      default: affect = M_ZNVS;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      held  <= '0;
    end else begin
      state <= next_state;
      if (accept) begin
        held <= req;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      done    <= 1'b0;
      result  <= '0;
      flags   <= FLAGS_RESET;
      pcLoad  <= 1'b0;
      pcValue <= 22'h000000;
    end else begin
      done   <= finish;
      pcLoad <= finish && pcOp;
      if (finish) begin
        result <= next_result;
        flags  <= next_flags;
      end
      if (finish && pcOp) begin
        pcValue <= {6'h00, cur.zPtr};
      end
    end
  end

  // checks
  wire logic [15:0] chkWord = {req.rdHigh, req.rd} + {8'h00, req.imm};
  wire logic [15:0] chkSu = 16'($signed({req.rd[7], req.rd}) * $signed({1'b0, req.rr}));
  wire logic [7:0]  chkSbc = req.rd - req.imm - {7'h00, flags[FLG_C]};

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  a_word_add_sum: assert property (accept && req.op == OP_ADD_IMM_WORD |=>
    !done ##1 done && result.wrWide && result.data == $past(chkWord, 2))
    else $error("word add result or timing wrong");
  a_word_sub_hflag: assert property (accept && req.op == OP_SUB_IMM_WORD |->
    ##2 done && flags[FLG_H] == $past(flags[FLG_H], 2))
    else $error("word subtract disturbed half carry");
  a_borrow_sub_val: assert property (accept && req.op == OP_SUB_IMM_BORROW |=>
    done && result.data[7:0] == $past(chkSbc))
    else $error("subtract with borrow wrong");
  a_and_imm_val: assert property (accept && req.op == OP_AND_IMM |=>
    done && result.data[7:0] == ($past(req.rd) & $past(req.imm)) && !flags[FLG_V])
    else $error("and immediate wrong");
  a_or_imm_carry: assert property (accept && req.op == OP_OR_IMM |=>
    done && flags[FLG_C] == $past(flags[FLG_C]) && flags[FLG_H] == $past(flags[FLG_H]))
    else $error("or immediate touched carry or half carry");
  a_test_no_write: assert property (accept && req.op == OP_TEST_ZM |=>
    done && !result.wrEn && flags[FLG_Z] == ($past(req.rd) == 8'h00))
    else $error("test operation wrong");
  a_set_bits_val: assert property (accept && req.op == OP_SET_BITS |=>
    done && result.data[7:0] == ($past(req.rd) | $past(req.imm)))
    else $error("set bits wrong");
  a_clear_bits_val: assert property (accept && req.op == OP_CLEAR_BITS |=>
    done && result.data[7:0] == ($past(req.rd) & ~$past(req.imm)))
    else $error("clear bits wrong");
  a_mult_signed_by_unsigned_product: assert property (accept && req.op == OP_MUL_SU |->
    ##2 done && result.toR1R0 && result.data == $past(chkSu, 2))
    else $error("signed by unsigned product wrong");
  a_frac_mult_signed_unsigned_shift: assert property (accept && req.op == OP_FMUL_SU |->
    ##2 done && result.data == {$past(chkSu[14:0], 2), 1'b0} && flags[FLG_C] == $past(chkSu[15], 2))
    else $error("fractional product wrong");
  a_jump_pc_load: assert property (accept && req.op == OP_JUMP_IND |=>
    !pcLoad ##1 pcLoad && pcValue == {6'h00, $past(req.zPtr, 2)} && flags == $past(flags, 2))
    else $error("indirect jump wrong");
  a_call_pc_load: assert property (accept && req.op == OP_CALL_IND |->
    ##2 pcLoad && pcValue[21:16] == 6'h00 && !result.wrEn)
    else $error("indirect call wrong");
  a_set_reg_flags: assert property (accept && req.op == OP_SET_REG |=>
    done && flags == $past(flags) && result.data[7:0] == 8'hff)
    else $error("set register changed flags");
  a_mul_two_cycle: assert property (accept && twoCyc |=>
    !reqReady && !done ##1 done && reqReady)
    else $error("two cycle timing wrong");

  c_word_add: cover property (accept && req.op == OP_ADD_IMM_WORD);
  c_mul_back_to_back: cover property (done && result.toR1R0 && accept && twoCyc);
  c_call_ind: cover property (pcLoad);
endmodule
`default_nettype wire

// file: tb/caif_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module caif_core_model (
  input  wire logic                   core_clk,
  input  wire logic                   reqReady,
  input  wire logic                   done,
  input  wire caif_pkg::caif_result_s result,
  output var  logic                   reqValid,
  output var  caif_pkg::caif_req_s    req
);
  import caif_pkg::*;
  logic [7:0] regs [0:31];
  int         dst = 0;
  initial begin
    reqValid = 1'b0;
    req = '0;
    foreach (regs[i]) regs[i] = 8'h00;
  end
  // write-back lands one edge after done, as in the register file
  always @(posedge core_clk) begin
    if (done && result.wrEn) begin
      if (result.toR1R0) begin
        regs[1] <= result.data[15:8];
        regs[0] <= result.data[7:0];
      end else begin
        if (result.wrWide) regs[dst+1] <= result.data[15:8];
        regs[dst] <= result.data[7:0];
      end
    end
  end
  // slow inserts idle cycles before the request; d stays below 31
  task automatic issue(input caif_op_e op, input int d, input int r, input logic [7:0] imm,
                       input logic [15:0] z, input int slow, output int cyc);
    int w;
    repeat (slow) @(posedge core_clk);
    @(posedge core_clk);
    #1;
    dst = d;
    reqValid = 1'b1;
    req = '{op, regs[d], regs[d+1], regs[r], imm, z};
    w = 0;
    while (reqReady !== 1'b1 && w < 8) begin
      @(posedge core_clk);
      #1;
      w++;
    end
    @(posedge core_clk);
    #1;
    reqValid = 1'b0;
    // released operands must not look valid, so they are inverted
    req = caif_req_s'(~req);
    cyc = 1;
    while (done !== 1'b1 && cyc < 8) begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
    // a request never taken counts as a timeout too
    if (w >= 8) cyc = 8;
  endtask
endmodule
`default_nettype wire

// file: tb/test_cpu_alu_and_indirect_flow.sv
`timescale 1ns/1ns
`default_nettype none
module test_cpu_alu_and_indirect_flow;
  import caif_pkg::*;
  logic         core_clk = 1'b0;
  logic         reset = 1'b1;
  logic         reqValid;
  caif_req_s    req;
  logic         reqReady;
  logic         done;
  caif_result_s result;
  logic [5:0]   flags;
  logic         pcLoad;
  logic [21:0]  pcValue;
  int           mismatches = 0;
  int           total_checks = 0;

  always #4 core_clk = ~core_clk;

  caif_alu u_dut (
    .core_clk (core_clk),
    .reset    (reset),
    .reqValid (reqValid),
    .req      (req),
    .reqReady (reqReady),
    .done     (done),
    .result   (result),
    .flags    (flags),
    .pcLoad   (pcLoad),
    .pcValue  (pcValue)
  );

  caif_core_model u_mod (
    .core_clk (core_clk),
    .reqReady (reqReady),
    .done     (done),
    .result   (result),
    .reqValid (reqValid),
    .req      (req)
  );

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmpVal(input logic [21:0] got, input logic [21:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic cmpFlags(input logic [5:0] exp);
    total_checks++;
    if (flags !== exp) begin
      mismatches++;
      $display("mismatch at %0t: flags got %h want %h", $time, flags, exp);
    end
  endtask

  // checks latency, flags and pc strobe in the done cycle
  task automatic run(input caif_op_e op, input int d, input int r, input logic [7:0] imm,
                     input logic [15:0] z, input int slow, input int expCyc,
                     input logic [5:0] expFl, input logic expPl);
    int cyc;
    u_mod.issue(op, d, r, imm, z, slow, cyc);
    if (cyc >= 8) begin
      mismatches++;
      end_of_test();
    end
    cmpVal(22'(cyc), 22'(expCyc), "latency");
    cmpFlags(expFl);
    cmpVal({21'h0, pcLoad}, {21'h0, expPl}, "pc load");
    @(posedge core_clk);
    #1;
  endtask

  task automatic t_borrow;
    u_mod.regs[2] = 8'h05;
    u_mod.regs[3] = 8'h10;
    run(OP_SUB_IMM_BORROW, 2, 0, 8'h05, 16'h0, 0, 1, 6'h00, 1'b0);
    cmpVal({14'h0, u_mod.regs[2]}, 22'h00, "borrow zero");
    run(OP_SUB_IMM_BORROW, 3, 0, 8'h01, 16'h0, 2, 1, 6'h20, 1'b0);
    cmpVal({14'h0, u_mod.regs[3]}, 22'h0f, "borrow half");
    $display("test borrow done");
  endtask

  task automatic t_word;
    u_mod.regs[24] = 8'hff;
    u_mod.regs[25] = 8'h7f;
    run(OP_ADD_IMM_WORD, 24, 0, 8'h01, 16'h0, 0, 2, 6'h2c, 1'b0);
    cmpVal({6'h0, u_mod.regs[25], u_mod.regs[24]}, 22'h8000, "word add");
    run(OP_SUB_IMM_WORD, 26, 0, 8'h01, 16'h0, 1, 2, 6'h35, 1'b0);
    cmpVal({6'h0, u_mod.regs[27], u_mod.regs[26]}, 22'hffff, "word sub");
    run(OP_SUB_IMM_BORROW, 4, 0, 8'h00, 16'h0, 0, 1, 6'h35, 1'b0);
    cmpVal({14'h0, u_mod.regs[4]}, 22'hff, "borrow in");
    $display("test word done");
  endtask

  task automatic t_logic;
    caif_op_e   ops [6] = '{OP_AND_IMM, OP_OR_IMM, OP_SET_BITS, OP_CLEAR_BITS,
                            OP_TEST_ZM, OP_AND_IMM};
    logic [7:0] msk [6] = '{8'h3c, 8'h3c, 8'h3c, 8'h3c, 8'h3c, 8'h5a};
    logic [7:0] res [6] = '{8'h24, 8'hbd, 8'hbd, 8'h81, 8'ha5, 8'h00};
    logic [5:0] fl  [6] = '{6'h21, 6'h35, 6'h35, 6'h35, 6'h35, 6'h23};
    for (int i = 0; i < 6; i++) begin
      u_mod.regs[5] = 8'ha5;
      run(ops[i], 5, 0, msk[i], 16'h0, i % 2, 1, fl[i], 1'b0);
      cmpVal({14'h0, u_mod.regs[5]}, {14'h0, res[i]}, "logic result");
      cmpVal({21'h0, result.wrEn}, {21'h0, ops[i] != OP_TEST_ZM}, "write enable");
    end
    $display("test logic done");
  endtask

  task automatic t_mult;
    u_mod.regs[16] = 8'h80;
    u_mod.regs[17] = 8'hff;
    u_mod.regs[18] = 8'h40;
    u_mod.regs[19] = 8'h02;
    // discriminates signed by unsigned from both plain and both signed
    run(OP_MUL_SU, 16, 17, 8'h00, 16'h0, 0, 2, 6'h21, 1'b0);
    cmpVal({6'h0, u_mod.regs[1], u_mod.regs[0]}, 22'h8080, "mult");
    run(OP_FMUL_SU, 18, 19, 8'h00, 16'h0, 1, 2, 6'h20, 1'b0);
    cmpVal({6'h0, u_mod.regs[1], u_mod.regs[0]}, 22'h0100, "frac mult");
    $display("test mult done");
  endtask

  task automatic t_flow;
    run(OP_JUMP_IND, 0, 0, 8'h00, 16'hbeef, 0, 2, 6'h20, 1'b1);
    cmpVal(pcValue, {6'h0, 16'hbeef}, "jump pc");
    cmpVal({21'h0, result.wrEn}, 22'h0, "jump write");
    run(OP_CALL_IND, 0, 0, 8'h00, 16'h1234, 1, 2, 6'h20, 1'b1);
    cmpVal(pcValue, {6'h0, 16'h1234}, "call pc");
    cmpVal({21'h0, pcLoad}, 22'h0, "pc load pulse");
    $display("test flow done");
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    reset = 1'b0;
    t_borrow();
    t_word();
    t_logic();
    t_mult();
    t_flow();
    end_of_test();
  end
endmodule
`default_nettype wire
